// >>> tgmc_consts.svh
// Register indices, field positions and reset values of the misc control bank.
`ifndef TGMC_CONSTS_SVH
`define TGMC_CONSTS_SVH
`define TGMC_IDX_SOFT_RESET 8'h10
`define TGMC_IDX_OUT_ENABLE 8'h11
`define TGMC_IDX_PIN_SELECT 8'h12
`define TGMC_IDX_ALIGN_CTRL 8'h13
`define TGMC_IDX_CORE_RESET 8'h14
`define TGMC_IDX_OSC_RESET 8'h15
`define TGMC_IDX_TEST_A 8'h16
`define TGMC_IDX_UPDATE_LINE 8'h17
`define TGMC_IDX_TEST_B 8'h18
`define TGMC_IDX_TEST_C 8'h19
`define TGMC_IDX_TEST_D 8'h1a
`define TGMC_IDX_TEST_E 8'h1b
`define TGMC_IDX_GATE_SELECT 8'h1c
`define TGMC_IDX_GATE_MASK 8'h1d
`define TGMC_IDX_UNUSED 8'h1e
`define TGMC_IDX_CNT_CLAMP 8'h1f
`define TGMC_ADDR_W 10
`define TGMC_PIN_SELECT_RST 5'h01
`define TGMC_ALIGN_RST 26'h0000061
`define TGMC_ALIGN_WMASK 26'h303f07f
`define TGMC_TEST_A_RST 28'h0000001
`define TGMC_TEST_E_RST 28'h000000a
`define TGMC_CNT_CLAMP_RST 2'h3
`define TGMC_B_EXT_EN 0
`define TGMC_B_POL 1
`define TGMC_B_SUSPEND 2
`define TGMC_B_MASK_LINE 4
`define TGMC_B_MASK_FIELD 5
`define TGMC_B_MASK_VERT 6
`define TGMC_B_EDGE 14
`define TGMC_B_SHUT_AFTER 15
`define TGMC_B_OUT_RESET 16
`define TGMC_B_CNT_ADV 17
`define TGMC_B_SW_ALIGN 24
`define TGMC_B_FORCE_SHUT 25
`define TGMC_B_INHIBIT 13
`define TGMC_B_OVERRIDE 24
`define TGMC_FIELD_CNT_W 8
`endif

// >>> tgmc_pkg.sv
// Types shared by the misc control bank.
package tgmc_pkg;
    typedef logic [31:0] tgmc_word_t;
    typedef logic [23:0] tgmc_vert_t;
endpackage

// >>> tgmc_misc_ctrl.sv
// Miscellaneous control register bank of the timing generator, APB slave.
//
// Contract
// [RULE1] Soft reset restores all registers, self-clears
// [RULE2] Outputs inactive until enabled at field sync
// [RULE3] Pin select: align input or reset, default 1
// [RULE4] Align enable accepts external pulses, default 1
// [RULE5] Polarity selects level; suspend stops clocks
// [RULE6] Suspend masks line, field, vertical outputs
// [RULE7] Single-edge option uses one pulse edge
// [RULE8] Shutter reset after alignment when enabled
// [RULE9] Shutter and general outputs reset on alignment
// [RULE10] Field counter advances or clears on alignment
// [RULE11] Software trigger aligns like pulse, self-clears
// [RULE12] Forced shutter reset held while bit set
// [RULE13] Timing core held in reset while zero
// [RULE14] Oscillator powered down while zero
// [RULE15] Update line selects frame update line
// [RULE16] Inhibit bit blocks frame updates
// [RULE17] Gate select marks vertical outputs as gates
// [RULE18] Override enable selects register gate mask
// [RULE19] Wide pixel counter enabled by default
// [RULE20] Clamp suppressed when blanking meets clamp
// [RULE21] Host writes documented test word values
// [RULE22] Frame registers apply at update line
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "tgmc_consts.svh"
module tgmc_misc_ctrl #(
    parameter int FCNT_W = `TGMC_FIELD_CNT_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire tgmc_pkg::tgmc_word_t pwdata,
    output tgmc_pkg::tgmc_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shared_pin,
    input wire logic field_sync_edge,
    input wire logic line_sync_edge,
    input wire logic [12:0] line_count,
    input wire logic blanking_pulse,
    input wire logic clamp_pulse,
    input wire logic line_sync_in,
    input wire logic field_sync_in,
    input wire tgmc_pkg::tgmc_vert_t vertical_clock_in,
    input wire tgmc_pkg::tgmc_vert_t field_gate_mask,
    output logic outputs_enabled,
    output logic ext_reset_n,
    output logic clock_suspend,
    output logic line_sync,
    output logic field_sync,
    output tgmc_pkg::tgmc_vert_t vertical_clock_outputs,
    output tgmc_pkg::tgmc_vert_t sensor_gate_select,
    output tgmc_pkg::tgmc_vert_t gate_mask_active,
    output logic align_event,
    output logic shutter_reset,
    output logic general_outputs_reset,
    output logic [FCNT_W-1:0] field_count,
    output logic timing_core_reset_n,
    output logic oscillator_reset_n,
    output logic wide_pixel_counter_enable,
    output logic clamp_enable,
    output logic frame_update
);
    import tgmc_pkg::*;

    logic soft_q, soft_d;
    logic out_en_q, out_en_d;
    logic out_live_q;
    logic [4:0] pin_sel_q;
    logic [25:0] align_q;
    logic core_q, osc_q;
    logic [27:0] test_a_q, test_b_q, test_c_q, test_d_q, test_e_q;
    logic [13:0] upd_q;
    logic [23:0] gsel_q;
    logic [24:0] gmask_q;
    logic [1:0] cc_q;
    logic pin_m_q, pin_s_q, pin_p_q;
    logic [FCNT_W-1:0] fcnt_q;
    logic shut_hold_q;
    logic gpo_rst_q;

    // Registers appear at byte address four times their index.
    wire [7:0] idx = paddr[`TGMC_ADDR_W-1:2];
    wire in_range = (paddr[11:`TGMC_ADDR_W] == 2'h0) && (paddr[1:0] == 2'h0);
    wire mapped = in_range && (idx >= `TGMC_IDX_SOFT_RESET)
        && (idx <= `TGMC_IDX_CNT_CLAMP);
    wire wr = psel && penable && pwrite && mapped;
    wire wr_hit_align = wr && (idx == `TGMC_IDX_ALIGN_CTRL);

    function automatic logic hit(input logic [7:0] i);
        hit = wr && (idx == i);
    endfunction

    // [RULE3] pin role select
    wire pin_is_align = !pin_sel_q[0];
    // [RULE4] external alignment gate
    wire ext_en = align_q[`TGMC_B_EXT_EN] && pin_is_align;
    // [RULE5] polarity applied
    wire pin_act = (pin_s_q == align_q[`TGMC_B_POL]);
    wire pin_act_prev = (pin_p_q == align_q[`TGMC_B_POL]);
    // [RULE7] single edge or whole pulse
    wire ext_evt = ext_en && (align_q[`TGMC_B_EDGE] ?
        (pin_act && !pin_act_prev) : pin_act);
    // [RULE11] software trigger event
    wire sw_evt = align_q[`TGMC_B_SW_ALIGN];
    wire evt = ext_evt || sw_evt;
    // [RULE5] clocks stop during pulse
    wire susp = ext_en && align_q[`TGMC_B_SUSPEND] && pin_act;
    // [RULE22] frame update moment
    // [RULE15] compare programmed line
    // [RULE16] inhibit blocks transfer
    wire upd_now = line_sync_edge && (line_count == upd_q[12:0])
        && !upd_q[`TGMC_B_INHIBIT];

    assign soft_d = soft_q ? 1'b0 : (hit(`TGMC_IDX_SOFT_RESET) && pwdata[0]);
    assign out_en_d = hit(`TGMC_IDX_OUT_ENABLE) ? pwdata[0] : out_en_q;

    // Pin is asynchronous, so two flops before use.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Idle high, so no false reset pulse follows release.
            pin_m_q <= 1'b1;
            pin_s_q <= 1'b1;
            pin_p_q <= 1'b1;
        end
        else
        begin
            pin_m_q <= shared_pin;
            pin_s_q <= pin_m_q;
            pin_p_q <= pin_s_q;
        end
    end

    // Soft reset takes one cycle; the write that sets it is its only trace.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            soft_q <= 1'b0;
            out_en_q <= 1'b0;
            pin_sel_q <= `TGMC_PIN_SELECT_RST;
            align_q <= `TGMC_ALIGN_RST;
            core_q <= 1'b0;
            osc_q <= 1'b0;
            test_a_q <= `TGMC_TEST_A_RST;
            test_b_q <= 28'h0;
            test_c_q <= 28'h0;
            test_d_q <= 28'h0;
            test_e_q <= `TGMC_TEST_E_RST;
            upd_q <= 14'h0;
            gsel_q <= 24'h0;
            gmask_q <= 25'h0;
            cc_q <= `TGMC_CNT_CLAMP_RST;
        end
        // [RULE1] restore defaults
        else if (soft_q)
        begin
            soft_q <= soft_d;
            out_en_q <= 1'b0;
            pin_sel_q <= `TGMC_PIN_SELECT_RST;
            align_q <= `TGMC_ALIGN_RST;
            core_q <= 1'b0;
            osc_q <= 1'b0;
            test_a_q <= `TGMC_TEST_A_RST;
            test_b_q <= 28'h0;
            test_c_q <= 28'h0;
            test_d_q <= 28'h0;
            test_e_q <= `TGMC_TEST_E_RST;
            upd_q <= 14'h0;
            gsel_q <= 24'h0;
            gmask_q <= 25'h0;
            cc_q <= `TGMC_CNT_CLAMP_RST;
        end
        else
        begin
            soft_q <= soft_d;
            out_en_q <= out_en_d;
            if (hit(`TGMC_IDX_PIN_SELECT))
                pin_sel_q <= pwdata[4:0];
            // [RULE11] trigger self-clears after event
            if (wr_hit_align)
                align_q <= pwdata[25:0] & `TGMC_ALIGN_WMASK;
            else
                align_q[`TGMC_B_SW_ALIGN] <= 1'b0;
            // [RULE13] core reset bit
            if (hit(`TGMC_IDX_CORE_RESET))
                core_q <= pwdata[0];
            // [RULE14] oscillator reset bit
            if (hit(`TGMC_IDX_OSC_RESET))
                osc_q <= pwdata[0];
            if (hit(`TGMC_IDX_TEST_A))
                test_a_q <= pwdata[27:0];
            if (hit(`TGMC_IDX_TEST_B))
                test_b_q <= pwdata[27:0];
            if (hit(`TGMC_IDX_TEST_C))
                test_c_q <= pwdata[27:0];
            if (hit(`TGMC_IDX_TEST_D))
                test_d_q <= pwdata[27:0];
            if (hit(`TGMC_IDX_TEST_E))
                test_e_q <= pwdata[27:0];
            if (hit(`TGMC_IDX_UPDATE_LINE))
                upd_q <= pwdata[13:0];
            if (hit(`TGMC_IDX_GATE_SELECT))
                gsel_q <= pwdata[23:0];
            if (hit(`TGMC_IDX_GATE_MASK))
                gmask_q <= pwdata[24:0];
            if (hit(`TGMC_IDX_CNT_CLAMP))
                cc_q <= pwdata[1:0];
        end
    end

    // Output enable is the only frame-updated control in this bank.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_live_q <= 1'b0;
        else if (soft_q)
            out_live_q <= 1'b0;
        else
        begin
            // [RULE2] disable at once, enable at field sync
            if (!out_en_q)
                out_live_q <= 1'b0;
            else if (field_sync_edge)
                out_live_q <= 1'b1;
        end
    end

    // Alignment effects on counter, shutter and general outputs.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fcnt_q <= '0;
            shut_hold_q <= 1'b0;
            gpo_rst_q <= 1'b0;
        end
        else
        begin
            // [RULE10] advance or clear counter
            if (evt)
                fcnt_q <= align_q[`TGMC_B_CNT_ADV] ?
                    fcnt_q + 1'b1 : '0;
            else if (field_sync_edge)
                fcnt_q <= fcnt_q + 1'b1;
            // [RULE8] [RULE9] reset pulses, registered one cycle after evt and as long as it
            shut_hold_q <= evt && (align_q[`TGMC_B_SHUT_AFTER]
                || align_q[`TGMC_B_OUT_RESET]);
            gpo_rst_q <= evt && align_q[`TGMC_B_OUT_RESET];
        end
    end

    assign align_event = evt;
    // [RULE12] forced shutter reset
    assign shutter_reset = shut_hold_q || align_q[`TGMC_B_FORCE_SHUT];
    assign general_outputs_reset = gpo_rst_q;
    assign field_count = fcnt_q;
    // [RULE3] reset role, active low
    assign ext_reset_n = pin_is_align ? 1'b1 : pin_s_q;
    assign clock_suspend = susp;
    assign outputs_enabled = out_live_q;
    // [RULE2] [RULE6] inactive level and suspend masks
    assign line_sync = out_live_q && line_sync_in
        && !(susp && align_q[`TGMC_B_MASK_LINE]);
    assign field_sync = out_live_q && field_sync_in
        && !(susp && align_q[`TGMC_B_MASK_FIELD]);
    assign vertical_clock_outputs = (out_live_q
        && !(susp && align_q[`TGMC_B_MASK_VERT])) ? vertical_clock_in : '0;
    // [RULE17] [RULE22] serial, acts at once
    assign sensor_gate_select = gsel_q;
    // [RULE18] mask source choice
    assign gate_mask_active = gmask_q[`TGMC_B_OVERRIDE] ?
        gmask_q[23:0] : field_gate_mask;
    // [RULE13] [RULE14] reset bar outputs
    assign timing_core_reset_n = core_q;
    assign oscillator_reset_n = osc_q;
    // [RULE19] counter width select
    assign wide_pixel_counter_enable = cc_q[0];
    // [RULE20] clamp suppression
    assign clamp_enable = clamp_pulse && !(cc_q[1] && blanking_pulse);
    assign frame_update = upd_now;

    // Read mux; the test words read back so software can check them.
    logic [27:0] rd;
    always_comb
    begin
        case (idx)
            `TGMC_IDX_SOFT_RESET: rd = {27'h0, soft_q};
            `TGMC_IDX_OUT_ENABLE: rd = {27'h0, out_en_q};
            `TGMC_IDX_PIN_SELECT: rd = {23'h0, pin_sel_q};
            `TGMC_IDX_ALIGN_CTRL: rd = {2'h0, align_q};
            `TGMC_IDX_CORE_RESET: rd = {27'h0, core_q};
            `TGMC_IDX_OSC_RESET: rd = {27'h0, osc_q};
            `TGMC_IDX_TEST_A: rd = test_a_q;
            `TGMC_IDX_UPDATE_LINE: rd = {14'h0, upd_q};
            `TGMC_IDX_TEST_B: rd = test_b_q;
            `TGMC_IDX_TEST_C: rd = test_c_q;
            `TGMC_IDX_TEST_D: rd = test_d_q;
            `TGMC_IDX_TEST_E: rd = test_e_q;
            `TGMC_IDX_GATE_SELECT: rd = {4'h0, gsel_q};
            `TGMC_IDX_GATE_MASK: rd = {3'h0, gmask_q};
            `TGMC_IDX_CNT_CLAMP: rd = {26'h0, cc_q};
            default: rd = 28'h0;
        endcase
    end

    assign prdata = (psel && !pwrite && mapped) ? {4'h0, rd} : 32'h0;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // [RULE1] trigger self-clears next cycle
    a_soft_clear: assert property (@(posedge pclk) disable iff (!presetn)
        soft_q |=> !soft_q && pin_sel_q == `TGMC_PIN_SELECT_RST)
        else $error("soft reset did not restore and clear");
    // [RULE2] no output while disabled
    a_out_inactive: assert property (@(posedge pclk) disable iff (!presetn)
        !out_live_q |-> !line_sync && !field_sync
        && vertical_clock_outputs == 24'h0)
        else $error("outputs active while disabled");
    // [RULE2] enable waits for field sync
    a_out_wait: assert property (@(posedge pclk) disable iff (!presetn)
        !out_live_q && !field_sync_edge |=> !out_live_q)
        else $error("outputs enabled without field sync");
    // [RULE11] software trigger lasts one cycle
    a_sw_selfclear: assert property (@(posedge pclk) disable iff (!presetn)
        sw_evt && !wr_hit_align |=> !sw_evt)
        else $error("software trigger did not clear");
    // [RULE10] counter clears when not advancing
    a_cnt_clear: assert property (@(posedge pclk) disable iff (!presetn)
        evt && !align_q[`TGMC_B_CNT_ADV] && !soft_q |=> fcnt_q == '0)
        else $error("field counter not cleared");
    // [RULE9] general outputs reset follows event
    a_gpo_reset: assert property (@(posedge pclk) disable iff (!presetn)
        evt && align_q[`TGMC_B_OUT_RESET] |=> general_outputs_reset
        && shutter_reset)
        else $error("output reset missing after alignment");
    // [RULE12] forced shutter held
    a_force_shut: assert property (@(posedge pclk) disable iff (!presetn)
        align_q[`TGMC_B_FORCE_SHUT] |-> shutter_reset)
        else $error("forced shutter reset not held");
    // [RULE16] inhibit blocks frame_update
    a_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
        upd_q[`TGMC_B_INHIBIT] |-> !frame_update)
        else $error("update happened while inhibited");
    // [RULE20] clamp suppressed in blanking
    a_clamp_mask: assert property (@(posedge pclk) disable iff (!presetn)
        cc_q[1] && blanking_pulse |-> !clamp_enable)
        else $error("clamp active during blanking");
endmodule // tgmc_misc_ctrl

// >>> test_timing_gen_misc_control.sv
// Self-checking bench for the misc control register bank.
`timescale 1ns/1ps
module test_timing_gen_misc_control;
    import tgmc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic shared_pin, field_sync_edge, line_sync_edge, blanking_pulse;
    logic clamp_pulse, line_sync_in, field_sync_in, outputs_enabled;
    logic ext_reset_n, clock_suspend, line_sync, field_sync, align_event;
    logic shutter_reset, general_outputs_reset, timing_core_reset_n;
    logic oscillator_reset_n, wide_pixel_counter_enable, clamp_enable;
    logic frame_update;
    logic [11:0] paddr;
    logic [12:0] line_count;
    logic [7:0] field_count, fc;
    tgmc_word_t pwdata, prdata, rd;
    tgmc_vert_t vertical_clock_in, field_gate_mask, vertical_clock_outputs;
    tgmc_vert_t sensor_gate_select, gate_mask_active;
    int num_errors, checked, cycles, pulses, resets, shuts;
    logic [7:0] ri [9] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
        8'h1b, 8'h1f};
    tgmc_word_t rv [9] = '{32'h0, 32'h0, 32'h1, 32'h61, 32'h0, 32'h0, 32'h1,
        32'ha, 32'h3};

    tgmc_misc_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .shared_pin, .field_sync_edge,
        .line_sync_edge, .line_count, .blanking_pulse, .clamp_pulse,
        .line_sync_in, .field_sync_in, .vertical_clock_in, .field_gate_mask,
        .outputs_enabled, .ext_reset_n, .clock_suspend, .line_sync,
        .field_sync, .vertical_clock_outputs, .sensor_gate_select,
        .gate_mask_active, .align_event, .shutter_reset,
        .general_outputs_reset, .field_count, .timing_core_reset_n,
        .oscillator_reset_n, .wide_pixel_counter_enable, .clamp_enable,
        .frame_update);

    task end_sim;
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // The request is held until pready is seen high at a rising edge.
    task apb(input logic wr, input logic [11:0] a, input tgmc_word_t wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] idx, input tgmc_word_t d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
    endtask

    task rdchk(input string n, input logic [7:0] idx, input tgmc_word_t e);
        apb(1'b0, {2'b00, idx, 2'b00}, 32'h0);
        chk(n, e, rd);
    endtask

    task idle(input int n);
        repeat (n) @(negedge pclk);
    endtask

    task line_pulse(input logic fu);
        @(posedge pclk) line_sync_edge <= 1'b1;
        @(negedge pclk) chk("frame_update", {31'h0, fu}, {31'h0, frame_update});
        @(posedge pclk) line_sync_edge <= 1'b0;
        idle(2);
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(negedge pclk)
    begin
        pulses += (align_event === 1'b1);
        resets += (general_outputs_reset === 1'b1);
        shuts += (shutter_reset === 1'b1);
    end

    // A hang is cut short well past the expected run length.
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles > 4000)
        begin
            num_errors++;
            end_sim;
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, field_sync_edge, line_sync_edge} = '0;
        {blanking_pulse, clamp_pulse, paddr, pwdata, line_count} = '0;
        {line_sync_in, field_sync_in, vertical_clock_in} = '0;
        shared_pin = 1'b1;
        field_gate_mask = 24'h00ff00;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++)
            rdchk("reset value", ri[i], rv[i]);
        chk("core", 32'h0, {31'h0, timing_core_reset_n});
        chk("osc", 32'h0, {31'h0, oscillator_reset_n});
        chk("wide", 32'h1, {31'h0, wide_pixel_counter_enable});
        apb(1'b1, 12'h400, 32'hffffffff);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b1, 12'h045, 32'h1);
        chk("slverr", 32'h1, {31'h0, err});
        rdchk("out enable", 8'h11, 32'h0);
        wr(8'h14, 32'h1);
        wr(8'h15, 32'h1);
        idle(2);
        chk("core", 32'h1, {31'h0, timing_core_reset_n});
        chk("osc", 32'h1, {31'h0, oscillator_reset_n});
        wr(8'h16, 32'h1);
        wr(8'h1b, 32'ha);
        rdchk("test word", 8'h16, 32'h1);
        wr(8'h11, 32'h1);
        idle(3);
        chk("enabled", 32'h0, {31'h0, outputs_enabled});
        @(posedge pclk) field_sync_edge <= 1'b1;
        @(posedge pclk) field_sync_edge <= 1'b0;
        idle(2);
        chk("enabled", 32'h1, {31'h0, outputs_enabled});
        @(posedge pclk) {blanking_pulse, clamp_pulse} <= 2'b11;
        idle(2);
        chk("clamp", 32'h0, {31'h0, clamp_enable});
        wr(8'h1f, 32'h1);
        idle(2);
        chk("clamp", 32'h1, {31'h0, clamp_enable});
        wr(8'h1f, 32'h2);
        idle(2);
        chk("wide", 32'h0, {31'h0, wide_pixel_counter_enable});
        fc = field_count;
        {pulses, resets} = '0;
        wr(8'h13, 32'h01030061);
        idle(4);
        chk("align pulses", 32'h1, pulses);
        chk("gpo resets", 32'h1, resets);
        chk("field count", {24'h0, fc + 8'h1}, {24'h0, field_count});
        rdchk("align reg", 8'h13, 32'h00030061);
        wr(8'h13, 32'h01000061);
        idle(4);
        chk("field count", 32'h0, {24'h0, field_count});
        wr(8'h13, 32'h02000061);
        idle(6);
        chk("shutter", 32'h1, {31'h0, shutter_reset});
        wr(8'h13, 32'h61);
        idle(3);
        chk("shutter", 32'h0, {31'h0, shutter_reset});
        wr(8'h17, 32'h5);
        idle(1);
        chk("select", 32'h0, {8'h0, sensor_gate_select});
        chk("mask", 32'hff00, {8'h0, gate_mask_active});
        wr(8'h1c, 32'ha5a5a5);
        wr(8'h1d, 32'h1123456);
        idle(1);
        chk("select", 32'ha5a5a5, {8'h0, sensor_gate_select});
        chk("mask", 32'h123456, {8'h0, gate_mask_active});
        line_pulse(1'b0);
        @(posedge pclk) line_count <= 13'h5;
        line_pulse(1'b1);
        wr(8'h17, 32'h2005);
        wr(8'h1c, 32'h3c);
        line_pulse(1'b0);
        chk("select", 32'h3c, {8'h0, sensor_gate_select});
        @(posedge pclk) {line_sync_in, field_sync_in} <= 2'b11;
        @(posedge pclk) vertical_clock_in <= 24'hffffff;
        wr(8'h13, 32'h67);
        @(posedge pclk) shared_pin <= 1'b0;
        wr(8'h12, 32'h0);
        idle(4);
        chk("suspend", 32'h0, {31'h0, clock_suspend});
        @(posedge pclk) shared_pin <= 1'b1;
        idle(4);
        chk("suspend", 32'h1, {31'h0, clock_suspend});
        chk("line", 32'h1, {31'h0, line_sync});
        chk("field", 32'h0, {31'h0, field_sync});
        chk("vert", 32'h0, {8'h0, vertical_clock_outputs});
        wr(8'h13, 32'h65);
        idle(4);
        chk("suspend", 32'h0, {31'h0, clock_suspend});
        wr(8'h13, 32'h60);
        {pulses, shuts} = '0;
        @(posedge pclk) shared_pin <= 1'b0;
        idle(4);
        chk("align pulses", 32'h0, pulses);
        @(posedge pclk) shared_pin <= 1'b1;
        idle(4);
        wr(8'h13, 32'hc061);
        @(posedge pclk) shared_pin <= 1'b0;
        idle(6);
        @(posedge pclk) shared_pin <= 1'b1;
        idle(4);
        chk("align pulses", 32'h1, pulses);
        chk("shutter pulses", 32'h1, shuts);
        chk("field count", 32'h0, {24'h0, field_count});
        wr(8'h10, 32'h1);
        idle(3);
        rdchk("soft reset", 8'h10, 32'h0);
        rdchk("pin select", 8'h12, 32'h1);
        rdchk("core reg", 8'h14, 32'h0);
        rdchk("update line", 8'h17, 32'h0);
        chk("line", 32'h0, {31'h0, line_sync});
        @(posedge pclk) shared_pin <= 1'b0;
        idle(4);
        chk("ext reset", 32'h0, {31'h0, ext_reset_n});
        @(posedge pclk) shared_pin <= 1'b1;
        idle(4);
        chk("ext reset", 32'h1, {31'h0, ext_reset_n});
        end_sim;
    end
endmodule // test_timing_gen_misc_control
